// File: rtl/wdt_guard_pkg.sv
/*
  constants, field layouts and state type of the watchdog mode and access guard.
  assumes a single system clock, an apb slave port and a cpu that acknowledges the prewarning interrupt.
*/
package wdt_guard_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GUARDED_CON = 8'h00;
  localparam logic [7:0] OFS_REQUEST_CON = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // fixed values
  // ----------------------------------------------------------------
  localparam logic [3:0] GUARD_ONES = 4'hf;
  localparam logic [15:0] TIMER_FIXED_LOAD = 16'hfffc;
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [13:0] PRESC_SLOW_END = 14'h3fff;
  localparam logic [13:0] PRESC_FAST_MASK = 14'h00ff;
  localparam logic [7:0] PW_RESET = 8'h00;
  localparam logic [15:0] REL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MODE_TIMEOUT = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_DISABLE = 2'b10,
    MODE_PREWARN = 2'b11
  } mode_t;

  // ----------------------------------------------------------------
  // register word layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] reload_value;
    logic [7:0] user_password_field;
    logic [3:0] guard;
    logic dr_bit;
    logic ir_bit;
    logic lock_bit;
    logic init_done_lock;
  } guarded_word_t;

  typedef struct packed {
    logic [29:0] zero;
    logic disable_request;
    logic input_rate_request;
  } request_word_t;

  typedef struct packed {
    logic [15:0] timer_count;
    logic [9:0] zero;
    logic prewarning_mode_flag;
    logic timeout_mode_flag;
    logic disable_mode_flag;
    logic rate_fast;
    logic overflow_error_flag;
    logic access_error_flag;
  } status_word_t;

  typedef struct packed {
    mode_t mode;
    logic [15:0] timer_count;
    logic [13:0] presc;
    logic tick;
    logic init_done_lock;
    logic access_lock_flag;
    logic [7:0] user_password_field;
    logic [15:0] reload_value;
    logic input_rate_request;
    logic disable_request;
    logic rate_fast;
    logic access_error_flag;
    logic overflow_error_flag;
    logic nmi;
    logic wdt_reset;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

endpackage

// File: rtl/watchdog_mode_and_access_guard.sv
/*
  watchdog with time-out, normal, disable and prewarning modes, password guarded control register,
  privilege guarded request register and read-only status, all behind an apb slave.
  assumes pprot[0] marks supervisor accesses and that the device reset output is routed back to presetn.
*/
`timescale 1ns/1ps
`default_nettype none
module watchdog_mode_and_access_guard
  import wdt_guard_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic nmi_ack,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic prewarn_interrupt_request,
  output logic init_done_lock,
  output logic wdt_reset_req
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  state_t q;
  state_t d;
  guarded_word_t wr_word;
  request_word_t req_word;
  logic setup_phase;
  logic access_phase;
  logic wr_guarded;
  logic wr_request;
  logic request_allowed;
  logic pw_ok;
  logic mod_ok;
  logic counting;
  logic overflow;

  assign wr_word = guarded_word_t'(pwdata);
  assign req_word = request_word_t'(pwdata);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable & q.pready;
  // prewarning freezes every write, including a late service password
  assign wr_guarded = access_phase & pwrite & (paddr == OFS_GUARDED_CON) & (q.mode != MODE_PREWARN);
  assign wr_request = access_phase & pwrite & (paddr == OFS_REQUEST_CON) & (q.mode != MODE_PREWARN);
  assign request_allowed = pprot[0] & ~q.init_done_lock;

  // password must echo current contents with bit 1 low and guard ones
  assign pw_ok = (wr_word.init_done_lock == q.init_done_lock) & ~wr_word.lock_bit &
                 (wr_word.ir_bit == q.input_rate_request) & (wr_word.dr_bit == q.disable_request) &
                 (wr_word.guard == GUARD_ONES) & (wr_word.user_password_field == q.user_password_field) &
                 (wr_word.reload_value == q.reload_value);
  assign mod_ok = wr_word.lock_bit & ~wr_word.ir_bit & ~wr_word.dr_bit & (wr_word.guard == GUARD_ONES);

  assign counting = q.tick & (q.mode != MODE_DISABLE);
  assign overflow = counting & (q.timer_count == TIMER_MAX);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.presc = q.presc + 14'h0001;
    // slow rate after reset since rate_fast resets low
    if (q.rate_fast) begin
      d.tick = ((q.presc & PRESC_FAST_MASK) == PRESC_FAST_MASK);
    end else begin
      d.tick = (q.presc == PRESC_SLOW_END);
    end

    if (counting) begin
      d.timer_count = q.timer_count + 16'h0001;
    end

    // apb: answer is prepared in setup so outputs stay registered
    d.pready = setup_phase;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (setup_phase) begin
      unique case (paddr)
        OFS_GUARDED_CON: begin
          d.prdata = {q.reload_value, q.user_password_field, 4'h0, q.disable_request,
                      q.input_rate_request, q.access_lock_flag, q.init_done_lock};
        end
        OFS_REQUEST_CON: begin
          d.prdata = {30'h0, q.disable_request, q.input_rate_request};
          d.pslverr = pwrite & ~request_allowed & (q.mode != MODE_PREWARN);
        end
        OFS_STATUS: begin
          d.prdata = {q.timer_count, 10'h000, q.mode == MODE_PREWARN, q.mode == MODE_TIMEOUT,
                      q.mode == MODE_DISABLE, q.rate_fast, q.overflow_error_flag, q.access_error_flag};
          d.pslverr = pwrite;
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    // request register takes effect only later, at init_done_lock set
    if (wr_request && request_allowed) begin
      d.input_rate_request = req_word.input_rate_request;
      d.disable_request = req_word.disable_request;
    end

    // guarded register: lock state picks password or modify access
    if (wr_guarded) begin
      if (q.access_lock_flag) begin
        if (pw_ok) begin
          d.access_lock_flag = 1'b0;
          if (q.mode != MODE_TIMEOUT) begin
            // a second password in time-out does not restart the window
            d.mode = MODE_TIMEOUT;
            d.timer_count = TIMER_FIXED_LOAD;
          end
        end else begin
          d.access_error_flag = 1'b1;
        end
      end else begin
        if (mod_ok) begin
          d.access_lock_flag = 1'b1;
          d.init_done_lock = wr_word.init_done_lock;
          d.user_password_field = wr_word.user_password_field;
          d.reload_value = wr_word.reload_value;
          if (q.mode == MODE_TIMEOUT && wr_word.init_done_lock) begin
            d.rate_fast = q.input_rate_request;
            d.access_error_flag = 1'b0;
            d.overflow_error_flag = 1'b0;
            if (q.disable_request) begin
              d.mode = MODE_DISABLE;
            end else begin
              d.mode = MODE_NORMAL;
              d.timer_count = wr_word.reload_value;
            end
          end
        end else begin
          d.access_error_flag = 1'b1;
        end
      end
    end

    // errors override the mode, count and lock set by a write of the same cycle
    if (overflow && q.mode != MODE_PREWARN) begin
      d.overflow_error_flag = 1'b1;
    end
    if (q.mode != MODE_PREWARN &&
        (overflow || (wr_guarded && (q.access_lock_flag ? ~pw_ok : ~mod_ok)))) begin
      d.mode = MODE_PREWARN;
      d.timer_count = TIMER_FIXED_LOAD;
      d.access_lock_flag = 1'b1;
    end

    // interrupt: set on entry wins over a simultaneous acknowledge
    if (nmi_ack) begin
      d.nmi = 1'b0;
    end
    if (q.mode != MODE_PREWARN && d.mode == MODE_PREWARN) begin
      d.nmi = 1'b1;
    end

    // end of the prewarning period; held until the chip reset arrives
    if (q.mode == MODE_PREWARN && overflow) begin
      d.wdt_reset = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.mode <= MODE_TIMEOUT;
      q.timer_count <= TIMER_FIXED_LOAD;
      q.presc <= '0;
      q.tick <= 1'b0;
      q.init_done_lock <= 1'b0;
      q.access_lock_flag <= 1'b1;
      q.user_password_field <= PW_RESET;
      q.reload_value <= REL_RESET;
      q.input_rate_request <= 1'b0;
      q.disable_request <= 1'b0;
      q.rate_fast <= 1'b0;
      q.access_error_flag <= 1'b0;
      q.overflow_error_flag <= 1'b0;
      q.nmi <= 1'b0;
      q.wdt_reset <= 1'b0;
      q.prdata <= '0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prewarn_interrupt_request = q.nmi;
  assign init_done_lock = q.init_done_lock;
  assign wdt_reset_req = q.wdt_reset;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_service_enters_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && q.access_lock_flag && pw_ok && q.mode == MODE_NORMAL && !overflow) |=>
      (q.mode == MODE_TIMEOUT && q.timer_count == TIMER_FIXED_LOAD && !q.access_lock_flag))
    else $error("valid password in normal mode did not start time-out");

  a_prewarn_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_PREWARN) |=> (q.mode == MODE_PREWARN) && $stable(q.reload_value) && $stable(q.disable_request))
    else $error("prewarning mode left or registers changed");

  a_prewarn_raises_nmi: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode != MODE_PREWARN ##1 q.mode == MODE_PREWARN) |-> prewarn_interrupt_request)
    else $error("no interrupt request on prewarning entry");

  a_disable_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_DISABLE ##1 q.mode == MODE_DISABLE) |-> $stable(q.timer_count))
    else $error("counter moved in disable mode");

  a_request_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (access_phase && pwrite && paddr == OFS_REQUEST_CON && !request_allowed && q.mode != MODE_PREWARN) |->
      pslverr ##1 ($stable(q.input_rate_request) && $stable(q.disable_request)))
    else $error("request register write not refused");

  a_modify_relocks: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && !q.access_lock_flag) |=> q.access_lock_flag)
    else $error("guarded register left unlocked after modify");

  a_normal_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_NORMAL && overflow) |=> (q.mode == MODE_PREWARN && q.overflow_error_flag))
    else $error("normal overflow did not enter prewarning");

  a_prewarn_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_PREWARN && overflow) |=> wdt_reset_req)
    else $error("no device reset at end of prewarning");

  a_normal_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT ##1 q.mode == MODE_NORMAL) |-> (q.timer_count == q.reload_value))
    else $error("normal mode not started from reload value");

  a_disable_pw_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && q.access_lock_flag && pw_ok && q.mode == MODE_DISABLE) |=>
      (q.mode == MODE_TIMEOUT && q.timer_count == TIMER_FIXED_LOAD))
    else $error("valid password in disable mode did not start time-out");

  a_disable_bad_access: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && q.mode == MODE_DISABLE && (q.access_lock_flag ? !pw_ok : !mod_ok)) |=>
      (q.mode == MODE_PREWARN && q.access_error_flag))
    else $error("invalid access in disable mode did not enter prewarning");

  a_timeout_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT && overflow) |=>
      (q.mode == MODE_PREWARN && q.overflow_error_flag && prewarn_interrupt_request))
    else $error("time-out overflow did not enter prewarning");

  a_timeout_bad_access: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT && wr_guarded && (q.access_lock_flag ? !pw_ok : !mod_ok)) |=>
      (q.mode == MODE_PREWARN && q.access_error_flag))
    else $error("invalid access in time-out did not enter prewarning");

  a_normal_bad_access: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_NORMAL && wr_guarded && (q.access_lock_flag ? !pw_ok : !mod_ok)) |=>
      (q.mode == MODE_PREWARN && q.access_error_flag))
    else $error("invalid access in normal mode did not enter prewarning");

  a_init_done_lock_normal: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT && wr_guarded && !q.access_lock_flag && mod_ok && wr_word.init_done_lock &&
      !q.disable_request && !overflow) |=> (q.mode == MODE_NORMAL))
    else $error("init_done_lock set without disable request did not enter normal mode");

  a_init_done_lock_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT && wr_guarded && !q.access_lock_flag && mod_ok && wr_word.init_done_lock &&
      q.disable_request && !overflow) |=> (q.mode == MODE_DISABLE))
    else $error("init_done_lock set with disable request did not enter disable mode");

  a_open_keeps_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode == MODE_TIMEOUT && wr_guarded && !q.access_lock_flag && mod_ok && !wr_word.init_done_lock &&
      !overflow) |=> (q.mode == MODE_TIMEOUT && !init_done_lock))
    else $error("clearing init_done_lock did not open the protection line in time-out");

  a_disable_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode != MODE_TIMEOUT && q.mode != MODE_DISABLE) |=>
      (q.mode != MODE_DISABLE))
    else $error("disable mode entered from outside time-out");

  a_rate_latched: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_guarded && !q.access_lock_flag && mod_ok) |=>
      $stable(q.rate_fast))
    else $error("counter rate changed outside a valid modify");

  a_request_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_phase && pwrite && paddr == OFS_REQUEST_CON && request_allowed && q.mode != MODE_PREWARN) |->
      !pslverr ##1 (q.input_rate_request == $past(req_word.input_rate_request)))
    else $error("permitted request register write refused or lost");

  a_password_unlocks: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && q.access_lock_flag && pw_ok && !overflow) |=>
      !q.access_lock_flag)
    else $error("valid password did not unlock the guarded register");

  a_lock_held: assert property (@(posedge pclk) disable iff (!presetn)
    (q.access_lock_flag && !(wr_guarded && pw_ok)) |=>
      q.access_lock_flag)
    else $error("guarded register unlocked without a valid password");

  a_line_follows_modify: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_guarded && !q.access_lock_flag && mod_ok) |=>
      (init_done_lock == $past(wr_word.init_done_lock)))
    else $error("protection line does not follow the modify write");

  a_open_only_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_done_lock && q.mode != MODE_PREWARN) |->
      (q.mode == MODE_TIMEOUT))
    else $error("protected registers open outside time-out mode");

  a_status_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    (access_phase && pwrite && paddr == OFS_STATUS) |->
      pslverr)
    else $error("status register write not refused");

  a_control_readable: assert property (@(posedge pclk) disable iff (!presetn)
    (access_phase && !pwrite && (paddr == OFS_GUARDED_CON || paddr == OFS_REQUEST_CON)) |->
      !pslverr)
    else $error("control register read refused");

  a_nmi_held: assert property (@(posedge pclk) disable iff (!presetn)
    (prewarn_interrupt_request && !nmi_ack) |=>
      prewarn_interrupt_request)
    else $error("interrupt request dropped without acknowledge");

  a_timeout_entry_load: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode != MODE_TIMEOUT ##1 q.mode == MODE_TIMEOUT) |->
      (q.timer_count == TIMER_FIXED_LOAD))
    else $error("time-out entry did not load the fixed count");

  a_prewarn_entry_load: assert property (@(posedge pclk) disable iff (!presetn)
    (q.mode != MODE_PREWARN ##1 q.mode == MODE_PREWARN) |->
      (q.timer_count == TIMER_FIXED_LOAD))
    else $error("prewarning entry did not load the fixed count");

endmodule
`default_nettype wire

// File: test/cpu_apb_model.sv
/*
  cpu side of the watchdog guard: an apb master with register access tasks.
  assumes one clock; the bench calls the tasks by hierarchical name.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_apb_model
  import wdt_guard_pkg::*;
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [2:0] pprot,
  output logic nmi_ack
);
  logic [31:0] rdata;
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
    pprot = 3'h0;
    nmi_ack = 1'b0;
  end
  // ----------------------------------------------------------------
  // bus transfer
  // ----------------------------------------------------------------
  // released address and data lines are inverted so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: a hang is ended by the bench watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // ----------------------------------------------------------------
  // access sequence
  // ----------------------------------------------------------------
  // password built from live bits of both control registers
  task automatic unlock();
    logic [31:0] c0;
    xfer(1'b0, OFS_GUARDED_CON, 32'h0, 3'h1);
    c0 = rdata;
    xfer(1'b0, OFS_REQUEST_CON, 32'h0, 3'h1);
    xfer(1'b1, OFS_GUARDED_CON, {c0[31:8], GUARD_ONES, rdata[1], rdata[0], 1'b0, c0[0]}, 3'h1);
  endtask
  task automatic modify(input logic eil, input logic [7:0] pw, input logic [15:0] rel);
    xfer(1'b1, OFS_GUARDED_CON, {rel, pw, GUARD_ONES, 3'b001, eil}, 3'h1);
  endtask
  task automatic ack();
    @(posedge pclk);
    nmi_ack <= 1'b1;
    @(posedge pclk);
    nmi_ack <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
/*
  self-checking bench for the watchdog guard: reset state, unlock, service, errors, disable.
  assumes the cpu model drives the apb port and the bench owns reset.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wdt_guard_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, nmi_ack, pready, pslverr, irq, idl, wrst;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pprot;
  int mismatches, check_count;
  watchdog_mode_and_access_guard dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .nmi_ack(nmi_ack), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prewarn_interrupt_request(irq), .init_done_lock(idl),
    .wdt_reset_req(wrst));
  cpu_apb_model cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .nmi_ack(nmi_ack));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    cpu.xfer(1'b0, a, 32'h0, 3'h1);
    chk(cpu.rdata & m, exp);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // bounded wait on the interrupt (0) or the reset request (1)
  task automatic wait_hi(input logic sel, input int lim);
    for (int i = 0; i < lim && (sel ? wrst : irq) !== 1'b1; i++) @(posedge pclk);
  endtask
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state();
    rdm(OFS_GUARDED_CON, 32'hffffffff, 32'h00000002);
    rdm(OFS_STATUS, 32'hffff003f, 32'hfffc0010);
    chk({31'h0, idl}, 32'h0);
    cpu.xfer(1'b0, 8'h0c, 32'h0, 3'h1);
    chk({31'h0, cpu.err}, 32'h1);
    cpu.xfer(1'b1, OFS_STATUS, 32'h0, 3'h1);
    chk({31'h0, cpu.err}, 32'h1);
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h1, 3'h0);
    chk({31'h0, cpu.err}, 32'h1);
    rdm(OFS_REQUEST_CON, 32'h3, 32'h0);
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h1, 3'h1);
    rdm(OFS_REQUEST_CON, 32'h3, 32'h1);
    rdm(OFS_STATUS, 32'h4, 32'h0);
  endtask
  task automatic t_enter_normal();
    cpu.unlock();
    rdm(OFS_GUARDED_CON, 32'h2, 32'h0);
    cpu.modify(1'b1, 8'h5a, 16'hfff0);
    rdm(OFS_GUARDED_CON, 32'hffffffff, 32'hfff05a07);
    rdm(OFS_STATUS, 32'hfffe003f, 32'hfff00004);
    chk({31'h0, idl}, 32'h1);
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h0, 3'h1);
    chk({31'h0, cpu.err}, 32'h1);
  endtask
  task automatic t_service_and_bad_pw();
    cpu.unlock();
    rdm(OFS_STATUS, 32'hfffe003f, 32'hfffc0014);
    cpu.modify(1'b1, 8'h5a, 16'hfff0);
    rdm(OFS_STATUS, 32'hfffe003f, 32'hfff00004);
    cpu.xfer(1'b1, OFS_GUARDED_CON, 32'h0, 3'h1);
    rdm(OFS_STATUS, 32'h3f, 32'h25);
    chk({31'h0, irq}, 32'h1);
    cpu.unlock();
    rdm(OFS_STATUS, 32'h3f, 32'h25);
    cpu.ack();
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wait_hi(1'b1, 1500);
    chk({31'h0, wrst}, 32'h1);
  endtask
  task automatic t_overflow();
    do_reset();
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h1, 3'h1);
    cpu.unlock();
    cpu.modify(1'b1, 8'h00, 16'hffff);
    wait_hi(1'b0, 600);
    rdm(OFS_STATUS, 32'h3f, 32'h26);
    wait_hi(1'b1, 1500);
    chk({31'h0, wrst}, 32'h1);
  endtask
  // service password, then init_done_lock cleared: the open window must run out
  task automatic t_open_window();
    do_reset();
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h1, 3'h1);
    cpu.unlock();
    cpu.modify(1'b1, 8'h00, 16'h0000);
    cpu.unlock();
    cpu.modify(1'b0, 8'h00, 16'h0000);
    rdm(OFS_STATUS, 32'h3f, 32'h14);
    chk({31'h0, idl}, 32'h0);
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h0, 3'h1);
    chk({31'h0, cpu.err}, 32'h0);
    wait_hi(1'b0, 1500);
    rdm(OFS_STATUS, 32'h3f, 32'h26);
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic t_disable();
    logic [15:0] c;
    do_reset();
    cpu.xfer(1'b1, OFS_REQUEST_CON, 32'h3, 3'h1);
    cpu.unlock();
    cpu.modify(1'b1, 8'h00, 16'h1234);
    rdm(OFS_STATUS, 32'h3f, 32'h0c);
    cpu.xfer(1'b0, OFS_STATUS, 32'h0, 3'h1);
    c = cpu.rdata[31:16];
    repeat (600) @(posedge pclk);
    rdm(OFS_STATUS, 32'hffff0000, {c, 16'h0});
    cpu.unlock();
    rdm(OFS_STATUS, 32'h3f, 32'h14);
    cpu.xfer(1'b1, OFS_GUARDED_CON, 32'h000000f6, 3'h1);
    rdm(OFS_STATUS, 32'h3f, 32'h25);
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // whole run needs well under 10k cycles
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  initial begin
    presetn = 1'b0;
    mismatches = 0;
    check_count = 0;
    do_reset();
    t_reset_state();
    t_enter_normal();
    t_service_and_bad_pw();
    t_overflow();
    t_open_window();
    t_disable();
    close_out();
  end
endmodule
`default_nettype wire
